/* File: bench/aso_rx_model.sv */
// receiving latch model that captures word and flag on the forwarded clock
`timescale 1ns/10ps
module aso_rx_model
   import aso_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // sample word pairs
   input wire logic [WORD_W-1:0] i_word_true,
   input wire logic [WORD_W-1:0] i_word_comp,
   // out-of-range pair
   input wire logic i_flag_true,
   input wire logic i_flag_comp,
   // forwarded clock pair
   input wire logic i_fwd_true,
   input wire logic i_fwd_comp
);
   // =========================================================
   // captured words and their age at capture
   logic [WORD_W:0] rx_q[$];
   int age_q[$];
   int pair_errs = 0;
   int age = 0;
   logic [WORD_W-1:0] prev_word = '0;
   logic fwd_prev = 1'b0;
   // =========================================================
   // latch; the fwd pin is registered on i_clock, so a sampled rise is seen one cycle after its own edge
   always @(posedge i_clock) begin
      if (i_rst) begin
         rx_q.delete();
         age_q.delete();
         fwd_prev = 1'b0;
         age = 0;
      end else begin
         if (i_fwd_true === 1'b1 && fwd_prev === 1'b0) begin
            rx_q.push_back({i_flag_true, i_word_true});
            age_q.push_back(age);
            // complement lines are compared too, since a receiver may use either
            if (i_word_comp !== ~i_word_true || i_flag_comp !== ~i_flag_true || i_fwd_comp !== 1'b0) begin
               pair_errs++;
            end
         end
         age = (i_word_true !== prev_word) ? 1 : age + 1;
         prev_word = i_word_true;
         fwd_prev = i_fwd_true;
      end
   end
endmodule // aso_rx_model

/* File: bench/test_aso_output_interface.sv */
// self-checking testbench of the sample output interface
`timescale 1ns/10ps
module test_aso_output_interface
   import aso_pkg::*;
;
   // =========================================================
   // signals
   localparam int NS = 24;
   logic clock, rst, pin_t, pin_c, rate_pin, rate_open, fmt_pin, fmt_open, above, below;
   logic [WORD_W-1:0] conv_code, word_t, word_c;
   logic ovr_t, ovr_c, fwd_t, fwd_c, locked, lk_seen;
   logic seen = 1'b0;
   logic fwd_prev = 1'b0;
   logic [WORD_W:0] watch = '0;
   logic [WORD_W:0] exp_q [NS];
   int cyc = 0;
   int t0 = 0;
   int t1 = 0;
   int fwd_rises = 0;
   int hi_cnt = 0;
   int last_hi = 0;
   int failures = 0;
   int checks_done = 0;
   // =========================================================
   // design and receiver
   aso_output_interface u_dut (.i_clock(clock), .i_rst(rst), .i_sample_clock_true(pin_t),
      .i_sample_clock_comp(pin_c), .i_half_rate_select(rate_pin), .i_half_rate_select_open(rate_open),
      .i_format_select(fmt_pin), .i_format_select_open(fmt_open), .i_conv_code(conv_code),
      .i_conv_above_full(above), .i_conv_below_full(below), .o_sample_word_true(word_t),
      .o_sample_word_comp(word_c), .o_overrange_true(ovr_t), .o_overrange_comp(ovr_c),
      .o_fwd_clock_true(fwd_t), .o_fwd_clock_comp(fwd_c), .o_dce_locked(locked));
   aso_rx_model u_rx (.i_clock(clock), .i_rst(rst), .i_word_true(word_t), .i_word_comp(word_c),
      .i_flag_true(ovr_t), .i_flag_comp(ovr_c), .i_fwd_true(fwd_t), .i_fwd_comp(fwd_c));
   // =========================================================
   // clock and monitors
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      fwd_prev <= fwd_t;
      if (fwd_t === 1'b1 && fwd_prev === 1'b0) fwd_rises <= fwd_rises + 1;
      if (fwd_t === 1'b1) hi_cnt <= hi_cnt + 1;
      else begin
         if (hi_cnt != 0) last_hi <= hi_cnt;
         hi_cnt <= 0;
      end
      if (!seen && {ovr_t, word_t} === watch) begin
         seen = 1'b1;
         t1 = cyc;
      end
   end
   // =========================================================
   // helpers
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [WORD_W:0] exp_of(input logic [WORD_W-1:0] code, input logic a, input logic b,
                                               input logic ob);
      logic [WORD_W-1:0] w;
      w = a ? {WORD_W{1'b1}} : (b ? {WORD_W{1'b0}} : code);
      if (!ob) w[WORD_W-1] = ~w[WORD_W-1];
      return {a | b, w};
   endfunction
   task automatic do_reset();
      rst = 1'b1;
      pin_t = 1'b0;
      pin_c = 1'b1;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      // let the synchronisers settle before the first pin edge
      repeat (4) @(negedge clock);
   endtask
   // one stream of NS samples; each sample is held for every rise that may tick
   task automatic run_stream(input logic full_p, input logic r_open, input logic ob_p, input logic f_open,
                             input int per, input int hi, input int kind);
      int reps, u, j, f_a, f_b, lat, n;
      logic ob, a, b;
      logic [WORD_W-1:0] code;
      reps = (full_p && !r_open) ? 1 : 2;
      ob = ob_p && !f_open;
      u = per * reps;
      rate_pin = full_p;
      rate_open = r_open;
      fmt_pin = ob_p;
      fmt_open = f_open;
      do_reset();
      for (int i = 0; i < NS; i++) begin
         code = WORD_W'(165 + 37 * i);
         a = (kind == 1) && (i % 3 == 0);
         b = (kind == 1) && (i % 3 == 1);
         exp_q[i] = exp_of(code, a, b, ob);
         if (i == 0) begin
            watch = exp_q[0];
            seen = 1'b0;
            t0 = cyc;
            t1 = 0;
         end
         if (i == 12) f_a = fwd_rises;
         if (i == 20) begin
            f_b = fwd_rises;
            lk_seen = locked;
         end
         conv_code = code;
         above = a;
         below = b;
         for (int r = 0; r < reps; r++) begin
            pin_t = 1'b1;
            pin_c = 1'b0;
            repeat (hi) @(negedge clock);
            pin_t = 1'b0;
            pin_c = 1'b1;
            repeat (per - hi) @(negedge clock);
         end
      end
      repeat (6) @(negedge clock);
      if (reps == 1) begin
         // synchroniser phase leaves one cycle of slack, far less than one sample period
         lat = t1 - t0;
         check("latency", 16'(8 * u + 4), 16'((lat >= 8 * u + 3 && lat <= 8 * u + 5) ? 8 * u + 4 : lat));
      end
      check("rises per 8 words", 16'd8, 16'(f_b - f_a));
      check("fwd high cycles", 16'(u / 2), 16'(last_hi));
      check("pair complements", 16'd0, 16'(u_rx.pair_errs));
      j = -1;
      n = u_rx.rx_q.size();
      for (int k = 0; k < n; k++) begin
         if (j < 0 && u_rx.rx_q[k] === exp_q[0]) j = k;
      end
      if (j < 0 || j + NS - 8 > n) begin
         check("first word found", 16'd1, 16'd0);
      end else begin
         for (int i = 0; i < NS - 8; i++) begin
            check("rx word", 16'(exp_q[i]), 16'(u_rx.rx_q[j + i]));
            check("fwd after word", 16'(FWD_DELAY_CYC), 16'(u_rx.age_q[j + i]));
         end
      end
   endtask
   // =========================================================
   // scenarios
   task automatic test_reset();
      do_reset();
      check("reset pairs", 16'h03FF, 16'({word_t, word_c} >> WORD_W) ^ 16'(word_c));
      check("reset flag fwd lock", 16'h000A, 16'({ovr_t, ovr_c, fwd_t, fwd_c, locked}));
   endtask
   task automatic test_full_offset();
      run_stream(1'b1, 1'b0, 1'b1, 1'b0, 4, 2, 0);
      check("locked fast", 16'd1, 16'(lk_seen));
   endtask
   task automatic test_twos_range();
      // short high phase: duty must still come out even
      run_stream(1'b1, 1'b0, 1'b0, 1'b0, 4, 1, 1);
   endtask
   task automatic test_range_offset();
      run_stream(1'b1, 1'b0, 1'b1, 1'b0, 4, 3, 1);
   endtask
   task automatic test_half_rate();
      run_stream(1'b0, 1'b0, 1'b1, 1'b0, 4, 2, 0);
   endtask
   task automatic test_open_pins();
      // both pins driven high but open, so the pulldowns must win
      run_stream(1'b1, 1'b1, 1'b1, 1'b1, 4, 2, 0);
   endtask
   task automatic test_slow_clock();
      run_stream(1'b1, 1'b0, 1'b1, 1'b0, 8, 4, 0);
      check("locked slow", 16'd0, 16'(lk_seen));
   endtask
   // =========================================================
   // main sequence and watchdog
   initial begin
      rst = 1'b1;
      pin_t = 1'b0;
      pin_c = 1'b1;
      rate_pin = 1'b1;
      rate_open = 1'b0;
      fmt_pin = 1'b1;
      fmt_open = 1'b0;
      conv_code = '0;
      above = 1'b0;
      below = 1'b0;
      @(negedge clock);
      test_reset();
      test_full_offset();
      test_twos_range();
      test_range_offset();
      test_half_rate();
      test_open_pins();
      test_slow_clock();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      complete_run();
   end
endmodule // test_aso_output_interface

/* File: verilog/aso_fifo.sv */
// small flop-based fifo with valid/ready on both sides
`timescale 1ns/10ps
module aso_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] count_q;
   logic wr;
   logic rd;

   assign o_ready = (count_q != FULL_CNT);
   assign o_valid = (count_q != '0);
   assign o_data = mem_q[rd_q];
   assign wr = i_valid & o_ready;
   assign rd = o_valid & i_ready;

   // =========================================================
   // storage
   always_ff @(posedge i_clock) begin
      if (wr) begin
         mem_q[wr_q] <= i_data;
      end
   end

   // =========================================================
   // pointers and fill level
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (wr) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
         end
         if (rd) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
         end
         case ({wr, rd})
            2'b10: count_q <= count_q + 1'b1;
            2'b01: count_q <= count_q - 1'b1;
            default: count_q <= count_q;
         endcase
      end
   end
endmodule // aso_fifo

/* File: verilog/aso_output_interface.sv */
// sample output interface of a pipelined sampling converter
// Functional notes
// R1: capture a sample on each true clock rise; at half rate the code captures only on every second rise
// R2: output appears eight sampling cycles after capture
// R3: word valid at next forwarded clock rise
// R4: forwarded clock rises fixed delay after edge
// R5: internal clock regenerated at 50% duty
// R6: equalizer always on; needs clock above 20MHz
// R7: rate pin low halves the update rate
// R8: rate pin defaults low when left open
// R9: rate pin high updates at full rate
// R10: format low two's complement, high offset binary
// R11: format pin defaults two's complement when open
// R12: ten-bit parallel word as true/complement pairs
// R13: flag out of range, true high, complement low
// R14: receiver latches word and flag on forwarded clock
// R15: out of range saturates to full-scale code
// R16: flag travels with its own data word
// R17: half rate: one forwarded rise per word
`timescale 1ns/10ps
module aso_output_interface
   import aso_pkg::*;
#(
   parameter int WORD_WIDTH = WORD_W,
   parameter int LATENCY = PIPE_LATENCY,
   parameter int BUF_DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // sampling clock pins
   input wire logic i_sample_clock_true,
   input wire logic i_sample_clock_comp,
   // strap pins, each with an unconnected indication
   input wire logic i_half_rate_select,
   input wire logic i_half_rate_select_open,
   input wire logic i_format_select,
   input wire logic i_format_select_open,
   // quantizer result, offset binary
   input wire logic [WORD_WIDTH-1:0] i_conv_code,
   input wire logic i_conv_above_full,
   input wire logic i_conv_below_full,
   // sample word pairs
   output logic [WORD_WIDTH-1:0] o_sample_word_true,
   output logic [WORD_WIDTH-1:0] o_sample_word_comp,
   // out-of-range pair
   output logic o_overrange_true,
   output logic o_overrange_comp,
   // forwarded clock pair
   output logic o_fwd_clock_true,
   output logic o_fwd_clock_comp,
   // equalizer status
   output logic o_dce_locked
);
   localparam int STAGES = LATENCY - 1;
   localparam int MSB = WORD_WIDTH - 1;
   localparam int BW = WORD_WIDTH + 1;

   // =========================================================
   // pin synchronisation
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_sync;
   logic clk_t;
   logic clk_c;
   logic mode_full;
   logic fmt_ob;

   // an open strap resolves low, like the pin's pulldown
   assign pins_raw[PIN_CLK_TRUE] = i_sample_clock_true;
   assign pins_raw[PIN_CLK_COMP] = i_sample_clock_comp;
   assign pins_raw[PIN_FULL_RATE] = i_half_rate_select & ~i_half_rate_select_open; // [R8]
   assign pins_raw[PIN_FMT_OB] = i_format_select & ~i_format_select_open; // [R11]

   aso_sync #(
      .WIDTH(PIN_W)
   ) u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(pins_raw),
      .o_sync(pins_sync)
   );

   assign clk_t = pins_sync[PIN_CLK_TRUE];
   assign clk_c = pins_sync[PIN_CLK_COMP];
   assign mode_full = pins_sync[PIN_FULL_RATE];
   assign fmt_ob = pins_sync[PIN_FMT_OB];

   // =========================================================
   // sampling clock edge
   logic lvl_q;
   logic lvl_prev_q;
   logic rise;

   // equal levels on both lines are a glitch: keep the last level
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         lvl_q <= 1'b0;
         lvl_prev_q <= 1'b0;
      end else begin
         if (clk_t & ~clk_c) begin
            lvl_q <= 1'b1;
         end else if (~clk_t & clk_c) begin
            lvl_q <= 1'b0;
         end
         lvl_prev_q <= lvl_q;
      end
   end

   assign rise = lvl_q & ~lvl_prev_q; // [R1]

   // =========================================================
   // input period check
   logic [CNT_W-1:0] in_cnt_q;
   logic locked_q;

   // no way to switch the equalizer off; only its health is reported
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         in_cnt_q <= '0;
         locked_q <= 1'b0;
      end else if (rise) begin
         in_cnt_q <= '0;
         locked_q <= (in_cnt_q < DCE_MAX_PERIOD_CYC); // [R6]
      end else if (in_cnt_q != '1) begin
         in_cnt_q <= in_cnt_q + 1'b1;
      end
   end

   assign o_dce_locked = locked_q;

   // =========================================================
   // rate selection
   logic div_phase_q;
   logic tick;

   assign tick = rise & (mode_full | div_phase_q); // [R7] [R9]

   // a rise that ticked always clears the phase, so a mode change never doubles up
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         div_phase_q <= 1'b0;
      end else if (rise) begin
         div_phase_q <= ~tick; // [R7]
      end
   end

   // =========================================================
   // duty-cycle equalizer on the update period
   logic [CNT_W-1:0] upd_cnt_q;
   logic [CNT_W-1:0] upd_period_q;
   logic eq_clk;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         upd_cnt_q <= '0;
         upd_period_q <= '0;
      end else if (tick) begin
         upd_period_q <= (upd_cnt_q == '1) ? '1 : upd_cnt_q + 1'b1;
         upd_cnt_q <= '0;
      end else if (upd_cnt_q != '1) begin
         upd_cnt_q <= upd_cnt_q + 1'b1;
      end
   end

   // high for the first half of each update period, whatever the input duty
   assign eq_clk = (upd_cnt_q < (upd_period_q >> 1)); // [R5] [R17]

   // =========================================================
   // forwarded clock
   logic [FWD_DELAY_CYC-1:0] fwd_t_q;
   logic [FWD_DELAY_CYC-1:0] fwd_c_q;

   // delay places the rise after the word has settled
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fwd_t_q <= {FWD_DELAY_CYC{RST_TRUE_LVL}};
         fwd_c_q <= {FWD_DELAY_CYC{RST_COMP_LVL}};
      end else begin
         fwd_t_q <= FWD_DELAY_CYC'({fwd_t_q, eq_clk}); // [R4] [R3]
         fwd_c_q <= FWD_DELAY_CYC'({fwd_c_q, ~eq_clk});
      end
   end

   assign o_fwd_clock_true = fwd_t_q[FWD_DELAY_CYC-1];
   assign o_fwd_clock_comp = fwd_c_q[FWD_DELAY_CYC-1];

   // =========================================================
   // capture and coding
   logic [MSB:0] sat_ob;
   logic [MSB:0] fmt_word;
   logic ovr;

   assign ovr = i_conv_above_full | i_conv_below_full; // [R13]
   assign sat_ob = i_conv_above_full ? {WORD_WIDTH{1'b1}} : (i_conv_below_full ? '0 : i_conv_code); // [R15]
   assign fmt_word = fmt_ob ? sat_ob : {~sat_ob[MSB], sat_ob[MSB-1:0]}; // [R10]

   // =========================================================
   // pipeline, flag kept beside its word
   logic [BW-1:0] pipe_q [STAGES];
   logic [STAGES-1:0] pipe_v_q;
   logic buf_in_ready;
   logic advance;
   logic push;

   // a full buffer freezes the pipeline instead of dropping words
   assign advance = tick & buf_in_ready;
   assign push = advance & pipe_v_q[STAGES-1];

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pipe_v_q <= '0;
         for (int i = 0; i < STAGES; i++) begin
            pipe_q[i] <= '0;
         end
      end else if (advance) begin
         pipe_q[0] <= {ovr, fmt_word}; // [R16] [R1]
         for (int i = 1; i < STAGES; i++) begin
            pipe_q[i] <= pipe_q[i-1]; // [R2]
         end
         pipe_v_q <= STAGES'({pipe_v_q, 1'b1});
      end
   end

   // =========================================================
   // output buffer, drained once per update
   logic buf_out_valid;
   logic [BW-1:0] buf_data;
   logic pop;

   aso_fifo #(
      .WIDTH(BW),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_valid(push),
      .o_ready(buf_in_ready),
      .i_data(pipe_q[STAGES-1]),
      .o_valid(buf_out_valid),
      .i_ready(tick),
      .o_data(buf_data)
   );

   assign pop = tick & buf_out_valid;

   // =========================================================
   // output pairs, each line its own flop
   logic [MSB:0] word_t_q;
   logic [MSB:0] word_c_q;
   logic ovr_t_q;
   logic ovr_c_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         word_t_q <= {WORD_WIDTH{RST_TRUE_LVL}};
         word_c_q <= {WORD_WIDTH{RST_COMP_LVL}};
         ovr_t_q <= RST_TRUE_LVL;
         ovr_c_q <= RST_COMP_LVL;
      end else if (pop) begin
         word_t_q <= buf_data[MSB:0]; // [R12] [R2]
         word_c_q <= ~buf_data[MSB:0];
         ovr_t_q <= buf_data[WORD_WIDTH]; // [R16] [R13]
         ovr_c_q <= ~buf_data[WORD_WIDTH];
      end
   end

   assign o_sample_word_true = word_t_q;
   assign o_sample_word_comp = word_c_q;
   assign o_overrange_true = ovr_t_q;
   assign o_overrange_comp = ovr_c_q;

   // =========================================================
   // checks
   localparam int AST_FWD_LAT = FWD_DELAY_CYC + 1;
   logic started_q;
   logic first_pop_q;
   logic [3:0] lat_cnt_q;
   logic last_rise_ticked_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         started_q <= 1'b0;
         first_pop_q <= 1'b0;
         lat_cnt_q <= '0;
         last_rise_ticked_q <= 1'b0;
      end else begin
         if (advance && !started_q) begin
            started_q <= 1'b1;
            lat_cnt_q <= 4'h1;
         end else if (tick && started_q && lat_cnt_q != 4'hF) begin
            lat_cnt_q <= lat_cnt_q + 4'h1;
         end
         if (pop) begin
            first_pop_q <= 1'b1;
         end
         if (rise) begin
            last_rise_ticked_q <= tick;
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_CAPTURE_ON_RISE: assert property (tick |-> rise && $past(clk_t) && !$past(clk_c)) // [R1]
      else $error("update without a sampling clock rise");
   AST_LATENCY: assert property ((pop && !first_pop_q) |-> lat_cnt_q == 4'(LATENCY)) // [R2]
      else $error("first word not delivered after the pipeline latency");
   AST_WORD_BEFORE_FWD: assert property ((pop && upd_cnt_q >= (upd_period_q >> 1))
      |=> !o_fwd_clock_true ##1 (o_fwd_clock_true && $stable(o_sample_word_true))) // [R3]
      else $error("word not stable at the forwarded clock rise");
   AST_FWD_DELAY: assert property (tick |-> ##AST_FWD_LAT o_fwd_clock_true) // [R4]
      else $error("forwarded clock not high at its fixed delay");
   AST_DUTY_HALF: assert property (($fell(eq_clk) && !$past(tick)) |-> upd_cnt_q == (upd_period_q >> 1)) // [R5]
      else $error("equalized clock high time is not half the period");
   AST_DCE_SLOW: assert property ((rise && in_cnt_q >= DCE_MAX_PERIOD_CYC) |=> !o_dce_locked) // [R6]
      else $error("slow sampling clock still reported as locked");
   AST_HALF_RATE: assert property ((rise && !mode_full && last_rise_ticked_q) |-> !tick) // [R7]
      else $error("half rate updated on two rises in a row");
   AST_RATE_OPEN: assert property (i_half_rate_select_open [*3] |=> !mode_full) // [R8]
      else $error("open rate pin did not resolve to half rate");
   AST_FULL_RATE: assert property ((rise && mode_full) |-> tick) // [R9]
      else $error("full rate skipped a sampling clock rise");
   AST_SAT_TWOS: assert property ((advance && i_conv_above_full && !fmt_ob)
      |=> pipe_q[0] == {1'b1, 1'b0, {(WORD_WIDTH-1){1'b1}}}) // [R15]
      else $error("positive overrange not saturated in two's complement");
   AST_SAT_OFFSET: assert property ((advance && i_conv_below_full && !i_conv_above_full && fmt_ob)
      |=> pipe_q[0] == {1'b1, {WORD_WIDTH{1'b0}}}) // [R15]
      else $error("negative overrange not saturated in offset binary");
   AST_PAIRS: assert property ((o_sample_word_comp == ~o_sample_word_true)
      && (o_overrange_comp != o_overrange_true) && (o_fwd_clock_comp != o_fwd_clock_true)) // [R12]
      else $error("differential pair lines not complementary");

   COV_HALF_RATE_WORD: cover property (pop && !mode_full);
   COV_FULL_RATE_WORD: cover property (pop && mode_full ##4 pop);
   COV_OVERRANGE_OUT: cover property (pop && buf_data[WORD_WIDTH] ##1 o_overrange_true);
   COV_LOCKED: cover property ($rose(o_dce_locked));
endmodule // aso_output_interface

/* File: verilog/aso_pkg.sv */
// constants shared by the sample output interface modules
package aso_pkg;
   // =========================================================
   // clocking
   localparam int CLOCK_MHZ = 100;
   localparam int CLOCK_PERIOD_PS = 10000;
   // forwarded clock delay after the sampling clock edge, 2.1 ns
   localparam int FWD_DELAY_PS = 2100;
   localparam int FWD_DELAY_RAW = (FWD_DELAY_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int FWD_DELAY_CYC = (FWD_DELAY_RAW < 1) ? 1 : FWD_DELAY_RAW;
   // =========================================================
   // duty-cycle equalizer
   localparam int DCE_MIN_MHZ = 20;
   localparam int CNT_W = 8;
   // longest input period, in cycles, still strictly faster than the minimum
   localparam logic [CNT_W-1:0] DCE_MAX_PERIOD_CYC = CNT_W'((CLOCK_MHZ + DCE_MIN_MHZ - 1) / DCE_MIN_MHZ - 1);
   // =========================================================
   // data path
   localparam int WORD_W = 10;
   localparam int PIPE_LATENCY = 8;
   localparam int FIFO_DEPTH = 4;
   // =========================================================
   // bit positions in the synchroniser vector
   localparam int PIN_W = 4;
   localparam int PIN_CLK_TRUE = 0;
   localparam int PIN_CLK_COMP = 1;
   localparam int PIN_FULL_RATE = 2;
   localparam int PIN_FMT_OB = 3;
   // =========================================================
   // reset values of the output pairs
   localparam logic RST_TRUE_LVL = 1'b0;
   localparam logic RST_COMP_LVL = 1'b1;
endpackage

/* File: verilog/aso_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module aso_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // pins
   input wire logic [WIDTH-1:0] i_async,
   // synchronised levels
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // aso_sync
